// [hw/phy_irq_counter_strap_regs.sv]
// Vendor management registers of the transceiver: interrupt control and
// status, receive error and disconnect counters, reset strap latch, all
// reached by a management frame slave on the serial MDC/MDIO pins.
// Assumes link/speed/duplex status, error pulses and the station address
// come from logic on clk_sys; MDC, MDIO and strap pins are asynchronous.
`timescale 1ns/1ns
`include "phy_mgmt_params.svh"

module phy_irq_counter_strap_regs (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  output logic            mgmt_irq_n,
  input  wire logic [4:0] phy_station_address,
  input  wire logic       link_status,
  input  wire logic       speed_status,
  input  wire logic       duplex_status,
  input  wire logic       rx_error_event,
  input  wire logic       txclk_pin,
  input  wire logic       cable_sense_pin,
  input  wire logic       col_pin,
  input  wire logic       rxclk_pin,
  input  wire logic       rxdv_pin,
  input  wire logic       rxer_pin,
  input  wire logic       link_led_pin,
  input  wire logic       speed_led_pin,
  input  wire logic       duplex_led_pin,
  input  wire logic       crs_pin,
  input  wire logic       rxd3_pin,
  input  wire logic       rxd2_pin,
  input  wire logic       rxd1_pin,
  input  wire logic       rxd0_pin
);

  // ==========================================================
  // Pin synchronisers
  logic                      mdc_s1_r;
  logic                      mdc_s2_r;
  logic                      mdc_d_r;
  logic                      mdio_s1_r;
  logic                      mdio_s2_r;
  logic [`STRAP_WIDTH-1:0]   strap_raw;
  logic [`STRAP_WIDTH-1:0]   strap_s1_r;
  logic [`STRAP_WIDTH-1:0]   strap_s2_r;

  // Strap pins in register bit order, 13 down to 0
  assign strap_raw = {txclk_pin, cable_sense_pin, col_pin, rxclk_pin, rxdv_pin, rxer_pin,
                      link_led_pin, speed_led_pin, duplex_led_pin, crs_pin,
                      rxd3_pin, rxd2_pin, rxd1_pin, rxd0_pin};

  // Serial pins: two flops each, then a third on MDC for edge detect
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mdc_s1_r  <= 1'b0;
      mdc_s2_r  <= 1'b0;
      mdc_d_r   <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end
    else
    begin
      mdc_s1_r  <= mdc;
      mdc_s2_r  <= mdc_s1_r;
      mdc_d_r   <= mdc_s2_r;
      mdio_s1_r <= mdio_i;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  // Strap pins, one two-flop stage per bit
  genvar gi;
  generate
    for (gi = 0; gi < `STRAP_WIDTH; gi++)
    begin : g_strap_sync
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          strap_s1_r[gi] <= 1'b0;
          strap_s2_r[gi] <= 1'b0;
        end
        else
        begin
          strap_s1_r[gi] <= strap_raw[gi];
          strap_s2_r[gi] <= strap_s1_r[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Strap latch: one capture after the synchronisers settle
  logic [1:0]                strap_cnt_r;
  logic                      strap_done_r;
  logic [`STRAP_WIDTH-1:0]   strap_latch_state_r;
  logic                      strap_take;

  assign strap_take = !strap_done_r && (strap_cnt_r == `STRAP_SETTLE);

  // Reset value stands until the pins have passed both flops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_cnt_r         <= 2'h0;
      strap_done_r        <= 1'b0;
      strap_latch_state_r <= `STRAP_RESET;
    end
    else if (strap_take)
    begin
      strap_done_r        <= 1'b1;
      strap_latch_state_r <= strap_s2_r;
    end
    else if (!strap_done_r)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  // ==========================================================
  // Status change detection and counters
  logic                      link_d_r;
  logic                      speed_d_r;
  logic                      duplex_d_r;
  logic                      link_evt;
  logic                      speed_evt;
  logic                      duplex_evt;
  logic                      drop_evt;
  logic [15:0]               rx_error_counter_r;
  logic [7:0]                link_drop_counter_r;

  assign link_evt   = link_status ^ link_d_r;
  assign speed_evt  = speed_status ^ speed_d_r;
  assign duplex_evt = duplex_status ^ duplex_d_r;
  assign drop_evt   = link_d_r && !link_status; // Disconnect is a link fall

  // Counters wrap; software sees them read-only
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      link_d_r            <= 1'b0;
      speed_d_r           <= 1'b0;
      duplex_d_r          <= 1'b0;
      rx_error_counter_r  <= 16'h0000;
      link_drop_counter_r <= 8'h00;
    end
    else
    begin
      link_d_r   <= link_status;
      speed_d_r  <= speed_status;
      duplex_d_r <= duplex_status;
      if (rx_error_event)
        rx_error_counter_r <= rx_error_counter_r + 16'h0001;
      if (drop_evt)
        link_drop_counter_r <= link_drop_counter_r + 8'h01;
    end
  end

  // ==========================================================
  // Interrupt register
  logic [3:0]                irq_mask_r;   // duplex, speed, link, global
  logic                      link_chg_r;
  logic                      speed_chg_r;
  logic                      duplex_chg_r;
  logic                      irq_status_r;
  logic                      mgmt_irq_n_r;
  logic                      link_chg_nxt;
  logic                      speed_chg_nxt;
  logic                      duplex_chg_nxt;
  logic                      irq_status_nxt;
  logic                      irq_rd_clr;
  logic                      mask_wr;
  logic [15:0]               wr_data;

  // A change in the read cycle survives the clear
  assign duplex_chg_nxt = (duplex_chg_r && !irq_rd_clr) || duplex_evt;
  assign speed_chg_nxt  = (speed_chg_r && !irq_rd_clr) || speed_evt;
  assign link_chg_nxt   = (link_chg_r && !irq_rd_clr) || link_evt;
  assign irq_status_nxt = !irq_mask_r[0] && (
                          (duplex_chg_nxt && !irq_mask_r[3]) ||
                          (speed_chg_nxt && !irq_mask_r[2]) ||
                          (link_chg_nxt && !irq_mask_r[1]));

  // Pin and status bit share one source so they never disagree
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_mask_r   <= `IRQ_MASK_RESET;
      link_chg_r   <= 1'b0;
      speed_chg_r  <= 1'b0;
      duplex_chg_r <= 1'b0;
      irq_status_r <= 1'b0;
      mgmt_irq_n_r <= 1'b1;
    end
    else
    begin
      if (mask_wr)
        irq_mask_r <= wr_data[`IRQ_DUPLEX_MASK_BIT:`IRQ_GLOBAL_MASK_BIT];
      link_chg_r   <= link_chg_nxt;
      speed_chg_r  <= speed_chg_nxt;
      duplex_chg_r <= duplex_chg_nxt;
      irq_status_r <= irq_status_nxt;
      mgmt_irq_n_r <= !irq_status_nxt;
    end
  end

  // ==========================================================
  // Read data selection
  logic [15:0]               irq_word;
  logic [15:0]               rd_data;
  logic [4:0]                hdr_reg;
  logic                      reg_mapped;

  // Reserved bits read as zero
  assign irq_word = {irq_status_r, 3'b000, irq_mask_r, 3'b000,
                     duplex_chg_r, speed_chg_r, link_chg_r, 1'b0, irq_status_r};
  assign rd_data  = (hdr_reg == `REG_IRQ_CTRL_STAT)  ? irq_word :
                    (hdr_reg == `REG_RX_ERR_CNT)     ? rx_error_counter_r :
                    (hdr_reg == `REG_LINK_DROP_CNT)  ? {8'h00, link_drop_counter_r} :
                    {2'b00, strap_latch_state_r};
  assign reg_mapped = (hdr_reg >= `REG_IRQ_CTRL_STAT) && (hdr_reg <= `REG_STRAP_LATCH);

  // ==========================================================
  // Management frame slave
  phy_mgmt_pkg::mgmt_state_t state_r;
  logic                      mdc_rise;
  logic [5:0]                ones_cnt_r;
  logic [3:0]                bit_cnt_r;
  logic [11:0]               hdr_sr_r;
  logic [12:0]               hdr_full;
  logic [4:0]                reg_sel_r;
  logic                      is_read_r;
  logic                      ta_second_r;
  logic [15:0]               shift_r;
  logic                      mdio_o_r;
  logic                      mdio_oe_r;
  logic                      hdr_last;
  logic                      hdr_ok;
  logic                      hdr_read;
  logic                      data_last;

  assign mdc_rise  = mdc_s2_r && !mdc_d_r;
  assign hdr_full  = {hdr_sr_r, mdio_s2_r};
  assign hdr_last  = (state_r == phy_mgmt_pkg::MF_HEADER) && mdc_rise
                     && (bit_cnt_r == `MGMT_HDR_BITS - 4'h1);
  assign hdr_read  = hdr_full[11:10] == `MGMT_OP_READ;
  assign hdr_reg   = hdr_last ? hdr_full[4:0] : reg_sel_r;
  assign hdr_ok    = hdr_full[12] && (hdr_full[9:5] == phy_station_address)
                     && reg_mapped && (hdr_read || hdr_full[11:10] == `MGMT_OP_WRITE);
  assign data_last = (state_r == phy_mgmt_pkg::MF_DATA) && mdc_rise
                     && (bit_cnt_r == `MGMT_DATA_BITS);
  assign irq_rd_clr = hdr_last && hdr_ok && hdr_read
                      && (hdr_full[4:0] == `REG_IRQ_CTRL_STAT);
  assign wr_data   = {shift_r[14:0], mdio_s2_r};
  assign mask_wr   = data_last && !is_read_r && (reg_sel_r == `REG_IRQ_CTRL_STAT);

  // Frame walk, advanced only on a sampled MDC rise
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r     <= phy_mgmt_pkg::MF_PREAMBLE;
      ones_cnt_r  <= 6'h00;
      bit_cnt_r   <= 4'h0;
      hdr_sr_r    <= 12'h000;
      reg_sel_r   <= 5'h00;
      is_read_r   <= 1'b0;
      ta_second_r <= 1'b0;
      shift_r     <= 16'h0000;
      mdio_o_r    <= 1'b0;
      mdio_oe_r   <= 1'b0;
    end
    else if (mdc_rise)
    begin
      case (state_r)
        phy_mgmt_pkg::MF_PREAMBLE:
        begin
          if (mdio_s2_r)
          begin
            if (ones_cnt_r != `MGMT_PREAMBLE_ONES)
              ones_cnt_r <= ones_cnt_r + 6'h01;
          end
          else if (ones_cnt_r == `MGMT_PREAMBLE_ONES)
          begin
            state_r   <= phy_mgmt_pkg::MF_HEADER; // First start bit seen
            bit_cnt_r <= 4'h0;
          end
          else
            ones_cnt_r <= 6'h00;
        end
        phy_mgmt_pkg::MF_HEADER:
        begin
          hdr_sr_r  <= hdr_full[11:0];
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (hdr_last)
          begin
            ones_cnt_r  <= 6'h00;
            reg_sel_r   <= hdr_full[4:0];
            is_read_r   <= hdr_read;
            shift_r     <= rd_data;
            ta_second_r <= 1'b0;
            // Foreign address or register: stay silent
            state_r     <= hdr_ok ? phy_mgmt_pkg::MF_TURNAROUND
                                  : phy_mgmt_pkg::MF_PREAMBLE;
          end
        end
        phy_mgmt_pkg::MF_TURNAROUND:
        begin
          ta_second_r <= 1'b1;
          if (!ta_second_r)
          begin
            mdio_oe_r <= is_read_r; // Drive the turnaround zero
            mdio_o_r  <= 1'b0;
          end
          else
          begin
            state_r   <= phy_mgmt_pkg::MF_DATA;
            bit_cnt_r <= 4'h0;
            mdio_o_r  <= shift_r[15];
            if (is_read_r)
              shift_r <= {shift_r[14:0], 1'b0};
          end
        end
        phy_mgmt_pkg::MF_DATA:
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          mdio_o_r  <= shift_r[15];
          shift_r   <= is_read_r ? {shift_r[14:0], 1'b0} : wr_data;
          if (data_last)
          begin
            state_r   <= phy_mgmt_pkg::MF_PREAMBLE; // Release after last bit
            mdio_oe_r <= 1'b0;
            mdio_o_r  <= 1'b0;
          end
        end
        default:
          state_r <= phy_mgmt_pkg::MF_PREAMBLE;
      endcase
    end
  end

  assign mdio_o     = mdio_o_r;
  assign mdio_oe    = mdio_oe_r;
  assign mgmt_irq_n = mgmt_irq_n_r;

endmodule

// [shared/phy_mgmt_params.svh]
// Constants for the management register bank: offsets, field positions,
// reset values and frame counts. Included by the design.
`ifndef PHY_MGMT_PARAMS_SVH
`define PHY_MGMT_PARAMS_SVH

// ==========================================================
// Register offsets on the management bus
`define REG_IRQ_CTRL_STAT   5'h15
`define REG_RX_ERR_CNT      5'h16
`define REG_LINK_DROP_CNT   5'h17
`define REG_STRAP_LATCH     5'h18

// ==========================================================
// Interrupt register fields
`define IRQ_PEND_BIT        15
`define IRQ_DUPLEX_MASK_BIT 11
`define IRQ_SPEED_MASK_BIT  10
`define IRQ_LINK_MASK_BIT   9
`define IRQ_GLOBAL_MASK_BIT 8
`define IRQ_DUPLEX_CHG_BIT  4
`define IRQ_SPEED_CHG_BIT   3
`define IRQ_LINK_CHG_BIT    2
`define IRQ_STATUS_BIT      0
`define IRQ_MASK_RESET      4'hF

// ==========================================================
// Strap latch register
`define STRAP_WIDTH         14
`define STRAP_RESET         14'h04E0

// ==========================================================
// Management frame counts and opcodes, strap settle count
`define MGMT_PREAMBLE_ONES  6'h20
`define MGMT_HDR_BITS       4'hD
`define MGMT_OP_READ        2'h2
`define MGMT_OP_WRITE       2'h1
`define MGMT_DATA_BITS      4'hF
`define STRAP_SETTLE        2'h2

`endif

// [shared/phy_mgmt_pkg.sv]
// Types for the management register bank.
// Assumes the constants header is on the include path.
package phy_mgmt_pkg;
  // ==========================================================
  // Management frame receiver states
  typedef enum logic [1:0] {
    MF_PREAMBLE,
    MF_HEADER,
    MF_TURNAROUND,
    MF_DATA
  } mgmt_state_t;
endpackage

// [test/mgmt_station_model.sv]
// Station management model: runs MDC/MDIO frames on request.
// Assumes MDIO has a pull-up; MDC rests low between frames.
`timescale 1ns/1ns
module mgmt_station_model (
  input  wire logic clk_sys,
  output logic      mdc,
  output logic      mdio_i,
  input  wire logic mdio_o,
  input  wire logic mdio_oe
);
  logic drv_r;
  logic bit_r;

  // Wire level: device, then station, else the pull-up
  assign mdio_i = mdio_oe ? mdio_o : (drv_r ? bit_r : 1'h1);

  initial
  begin
    mdc = 1'h0;
    drv_r = 1'h0;
    bit_r = 1'h1;
  end

  // Slow MDC (17 clocks a bit) so the block's synchronisers keep up
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge clk_sys);
      drv_r = (op == 2'h1) || (i < 46);
      bit_r = bits[63 - i];
      repeat (8) @(negedge clk_sys);
      mdc = 1'h1;
      if (i >= 48)
        rd = {rd[14:0], mdio_i};
      repeat (8) @(negedge clk_sys);
      mdc = 1'h0;
    end
    drv_r = 1'h0;
  endtask
endmodule

// [test/phy_irq_counter_strap_regs_sva.sv]
// Checker for the management register bank, watching its pins only.
// Assumes MDC halves of at least 8 system clocks and bind to the top module.
`timescale 1ns/1ns
module phy_irq_counter_strap_regs_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic mgmt_irq_n,
  input wire logic link_status,
  input wire logic speed_status,
  input wire logic duplex_status
);
  // ====================
  // Helper logic
  logic       mdc_prev_r;
  logic [3:0] since_mdc_r;
  logic [3:0] since_mdc_nxt;
  logic [2:0] stat_prev_r;
  logic [2:0] stat_now;
  logic [3:0] evt_hist_r;

  // Age of the last MDC rise; saturates so idle time stays visible
  assign stat_now = {duplex_status, speed_status, link_status};
  assign since_mdc_nxt = (mdc && !mdc_prev_r) ? 4'h0 :
                         (since_mdc_r == 4'hF) ? 4'hF : since_mdc_r + 4'h1;

  // Status copy resets to 0, as the block's own copy does
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mdc_prev_r  <= 1'h0;
      since_mdc_r <= 4'hF;
      stat_prev_r <= 3'h0;
      evt_hist_r  <= 4'h0;
    end
    else
    begin
      mdc_prev_r  <= mdc;
      since_mdc_r <= since_mdc_nxt;
      stat_prev_r <= stat_now;
      evt_hist_r  <= {evt_hist_r[2:0], stat_now != stat_prev_r};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // ====================
  // Properties
  property p_rst_idle;
    $rose(nrst) |-> (mgmt_irq_n && !mdio_oe) [*8];
  endproperty
  property p_irq_cause;
    $fell(mgmt_irq_n) |-> (|evt_hist_r) || (since_mdc_r < 4'hA);
  endproperty
  property p_irq_release;
    $rose(mgmt_irq_n) |-> since_mdc_r < 4'hA;
  endproperty
  // Only an interrupt-register read or mask-write frame releases the pin, so a quiet bus keeps it low
  property p_irq_hold;
    $fell(mgmt_irq_n) && (since_mdc_r > 4'h7) |-> !mgmt_irq_n [*3];
  endproperty
  property p_irq_quiet;
    (since_mdc_r == 4'hF) && !(|evt_hist_r) |-> $stable(mgmt_irq_n);
  endproperty
  property p_oe_start;
    $rose(mdio_oe) |-> !mdio_o && (since_mdc_r > 4'h0) && (since_mdc_r < 4'h7);
  endproperty
  property p_oe_hold;
    $rose(mdio_oe) |-> mdio_oe [*6];
  endproperty
  property p_o_timing;
    (mdio_oe && $changed(mdio_o)) || $changed(mdio_oe) |-> since_mdc_r < 4'h7;
  endproperty

  a_rst_idle: assert property (p_rst_idle) else $error("pin busy after reset");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  a_irq_release: assert property (p_irq_release) else $error("irq freed idle");
  a_irq_hold: assert property (p_irq_hold) else $error("irq not held");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq moved idle");
  a_oe_start: assert property (p_oe_start) else $error("bad turnaround");
  a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
  a_o_timing: assert property (p_o_timing) else $error("mdio moved late");

  // Main scenarios reached
  c_irq: cover property ($fell(mgmt_irq_n));
  c_read: cover property ($rose(mdio_oe));
  c_clear: cover property ($rose(mgmt_irq_n));
endmodule

bind phy_irq_counter_strap_regs phy_irq_counter_strap_regs_sva chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_o(mdio_o),
  .mdio_oe(mdio_oe), .mgmt_irq_n(mgmt_irq_n), .link_status(link_status),
  .speed_status(speed_status), .duplex_status(duplex_status)
);

// [test/phy_irq_counter_strap_regs_tb_top.sv]
// Self-checking bench for the management register bank.
// Assumes the station model serves every register access.
`timescale 1ns/1ns
module phy_irq_counter_strap_regs_tb_top;
  localparam logic [4:0] PHY_ADDR = 5'h05;
  localparam int         WDOG_NS  = 4_000_000; // ~35 frames of 1.1k clocks, twice over
  logic        clk_sys = 1'h0;
  logic        nrst = 1'h0;
  logic        mdc;
  logic        mdio_i;
  logic        mdio_o;
  logic        mdio_oe;
  logic        mgmt_irq_n;
  logic [2:0]  stat = 3'h0;
  logic        rx_err = 1'h0;
  logic [13:0] straps = 14'h2935;
  logic [15:0] rd;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          drops = 0;

  // Clock, 50 ns
  always #25 clk_sys = ~clk_sys;

  // ====================
  // Design and station
  phy_irq_counter_strap_regs dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mgmt_irq_n(mgmt_irq_n),
    .phy_station_address(PHY_ADDR), .link_status(stat[0]),
    .speed_status(stat[1]), .duplex_status(stat[2]), .rx_error_event(rx_err),
    .txclk_pin(straps[13]), .cable_sense_pin(straps[12]), .col_pin(straps[11]),
    .rxclk_pin(straps[10]), .rxdv_pin(straps[9]), .rxer_pin(straps[8]),
    .link_led_pin(straps[7]), .speed_led_pin(straps[6]), .duplex_led_pin(straps[5]),
    .crs_pin(straps[4]), .rxd3_pin(straps[3]), .rxd2_pin(straps[2]),
    .rxd1_pin(straps[1]), .rxd0_pin(straps[0])
  );
  mgmt_station_model sm_u (
    .clk_sys(clk_sys), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe)
  );

  // ====================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    tests_run++;
    if ((got & m) !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got & m, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] pa, input logic [4:0] ra,
                     input logic [15:0] exp, input logic [15:0] m);
    sm_u.frame(2'h2, pa, ra, 16'h0000, rd);
    chk(rd, exp, m);
  endtask
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    sm_u.frame(2'h1, pa, ra, wd, rd);
  endtask
  // Flip status levels {duplex,speed,link}; count link falls
  task automatic tog(input logic [2:0] w);
    @(negedge clk_sys);
    drops += int'(w[0] & stat[0]);
    stat ^= w;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ====================
  // Scenarios
  task automatic t_reset(input logic [13:0] p);
    stat = 3'h0;
    straps = p;
    nrst = 1'h0;
    repeat (16) @(negedge clk_sys);
    nrst = 1'h1;
    drops = 0;
    repeat (5) @(negedge clk_sys);
    rdc(PHY_ADDR, 5'h15, 16'h0F00, 16'hFFFF);
    rdc(PHY_ADDR, 5'h16, 16'h0000, 16'hFFFF);
    rdc(PHY_ADDR, 5'h17, 16'h0000, 16'hFFFF);
    rdc(PHY_ADDR, 5'h18, {2'h0, p}, 16'hFFFF);
  endtask
  task automatic t_irq;
    wr(PHY_ADDR, 5'h15, 16'h0000);
    tog(3'h1);
    chk({15'h0000, mgmt_irq_n}, 16'h0000, 16'h0001);
    rdc(PHY_ADDR, 5'h15, 16'h8005, 16'hFFFF);
    chk({15'h0000, mgmt_irq_n}, 16'h0001, 16'h0001);
    tog(3'h6);
    rdc(PHY_ADDR, 5'h15, 16'h8019, 16'hFFFF);
    rdc(PHY_ADDR, 5'h15, 16'h0000, 16'hFFFF);
  endtask
  // Each event masked alone, then only the global mask
  task automatic t_masks;
    for (int k = 0; k < 3; k++)
    begin
      wr(PHY_ADDR, 5'h15, 16'h0200 << k);
      tog(3'h1 << k);
      chk({15'h0000, mgmt_irq_n}, 16'h0001, 16'h0001);
      rdc(PHY_ADDR, 5'h15, 16'h0200 << k, 16'h8F01);
    end
    wr(PHY_ADDR, 5'h15, 16'h0100);
    tog(3'h7);
    chk({15'h0000, mgmt_irq_n}, 16'h0001, 16'h0001);
    rdc(PHY_ADDR, 5'h15, 16'h0100, 16'h8F01);
  endtask
  // Back-to-back errors; enough link falls to wrap 8 bits
  task automatic t_counters;
    @(negedge clk_sys);
    rx_err = 1'h1;
    repeat (7) @(negedge clk_sys);
    rx_err = 1'h0;
    repeat (514) tog(3'h1);
    rdc(PHY_ADDR, 5'h16, 16'h0007, 16'hFFFF);
    rdc(PHY_ADDR, 5'h17, {8'h00, 8'(drops)}, 16'hFFFF);
  endtask
  // 5'h14 is the own address bit-reversed, so LSB-first decode fails
  task automatic t_refuse;
    wr(PHY_ADDR, 5'h16, 16'hFFFF);
    wr(PHY_ADDR, 5'h17, 16'hFFFF);
    wr(PHY_ADDR, 5'h18, 16'hFFFF);
    wr(PHY_ADDR, 5'h15, 16'hFFFF);
    wr(5'h14, 5'h15, 16'h0000);
    rdc(PHY_ADDR, 5'h16, 16'h0007, 16'hFFFF);
    rdc(PHY_ADDR, 5'h17, {8'h00, 8'(drops)}, 16'hFFFF);
    rdc(PHY_ADDR, 5'h18, {2'h0, straps}, 16'hFFFF);
    rdc(PHY_ADDR, 5'h15, 16'h0F00, 16'hFFE3);
    rdc(5'h14, 5'h15, 16'hFFFF, 16'hFFFF);
    rdc(PHY_ADDR, 5'h14, 16'hFFFF, 16'hFFFF);
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #WDOG_NS;
    error_cnt++;
    end_of_test();
  end
  // Main sequence; second reset comes last, with new straps
  initial
  begin
    t_reset(14'h2935);
    t_irq();
    t_masks();
    t_counters();
    t_refuse();
    t_reset(14'h16CA);
    end_of_test();
  end
endmodule
